// ### rtl/zqictl_defines.vh
// Purpose: constants shared by the impedance control register bank
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   instance n has its pair at byte addresses 8*n and 8*n + 4
`ifndef ZQICTL_DEFINES_VH
`define ZQICTL_DEFINES_VH

// ************************************************************
// address map
// ************************************************************
`define ZQI_ADDR_W      8
`define ZQI_CTL_SPAN    8'h20
`define ZQI_INIT_ADDR   8'h20
`define ZQI_STAT_ADDR   8'h24

// ************************************************************
// first control register fields
// ************************************************************
`define ZQI_PD_BIT      31
`define ZQI_EN_BIT      30
`define ZQI_BYP_BIT     29
`define ZQI_OVR_BIT     28
`define ZQI_CODE_MSB    27
`define ZQI_FIRST_RST   32'h4000_014A
`define ZQI_CODE_RST    28'h000_014A

// ************************************************************
// second control register fields
// ************************************************************
`define ZQI_PU_BIT      16
`define ZQI_ODT_MSB     7
`define ZQI_ODT_LSB     4
`define ZQI_DRV_MSB     3
`define ZQI_SECOND_RST  32'h0000_007B
`define ZQI_SECOND_MASK 32'h0001_00FF

// ************************************************************
// init and status register fields
// ************************************************************
`define ZQI_TRIG_BIT    0
`define ZQI_BUSY_LSB    0
`define ZQI_DONE_LSB    8
`define ZQI_BYPD_LSB    12

`endif

// ### rtl/zqictl_cal_unit.v
// Purpose: one impedance calibration sequencer and pad code select
// Assumes: engine codes and done come from logic on clk
// Notes:   one instance per register pair
`timescale 1ns/1ps
`default_nettype none
`include "zqictl_defines.vh"

module zqictl_cal_unit (
   input  wire        clk,           // system clock
   input  wire        resetn,        // async reset, active low
   input  wire        ce,            // clock enable
   input  wire        calEnable,     // calibration enable bit
   input  wire        powerDown,     // block power-down bit
   input  wire        bypass,        // calibration bypass bit
   input  wire        overrideEn,    // override enable bit
   input  wire [27:0] overrideCodes, // software codes
   input  wire        trigger,       // calibration trigger pulse
   input  wire [27:0] engineCodes,   // codes from calibration engine
   input  wire        engineDone,    // engine finished
   output reg         calStart,      // start pulse to engine
   output reg         calBusy,       // calibration running
   output reg         calEnd,        // end pulse, done or bypassed
   output reg         calBypassed,   // end pulse caused by bypass
   output reg  [27:0] padCodes       // codes applied to the pads
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg [27:0] autoCode_reg;

   // ************************************************************
   // sequencer
   // ************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         calBusy      <= ST_IDLE;
         calStart     <= 1'b0;
         calEnd       <= 1'b0;
         calBypassed  <= 1'b0;
         autoCode_reg <= `ZQI_CODE_RST;
         padCodes     <= `ZQI_CODE_RST;
      end else if (ce) begin
         calStart    <= 1'b0;
         calEnd      <= 1'b0;
         calBypassed <= 1'b0;
         case (calBusy)
            ST_IDLE: begin
               if (trigger && calEnable && !powerDown) begin
                  calBusy  <= ST_RUN;
                  calStart <= 1'b1;
               end
            end
            ST_RUN: begin
               if (powerDown) begin
                  calBusy <= ST_IDLE;
               end else if (bypass) begin
                  calBusy     <= ST_IDLE;
                  calEnd      <= 1'b1;
                  calBypassed <= 1'b1;
               end else if (engineDone) begin
                  calBusy      <= ST_IDLE;
                  calEnd       <= 1'b1;
                  autoCode_reg <= engineCodes;
               end
            end
            default: calBusy <= ST_IDLE;
         endcase
         if (overrideEn) begin
            padCodes <= overrideCodes;
         end else begin
            padCodes <= autoCode_reg;
         end
      end
   end

endmodule // zqictl_cal_unit
`default_nettype wire

// ### rtl/zqictl_regs.v
// Purpose: register bank for four impedance calibration instances
// Assumes: calibration engine and DFI update request run on clk
// Notes:   read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "zqictl_defines.vh"

// What this block does
// - four instances, each with a first and second control register
// - power-down bit 31 powers the instance down; resets to zero
// - enable bit 30 resets to one; enabled instances not powered down calibrate on trigger
// - trigger comes from software init bit or DFI update request
// - bypass bit 29 ends a running calibration; resets to zero
// - override bit 28 drives pad codes from software data
// - with override clear, pads take the calibrated codes
// - override data in bits 27..0, reset value 0x014A
// - pull-up termination bits 27..21, pull-down bits 20..14
// - pull-up drive bits 13..7, pull-down drive bits 6..0
// - second register bit 16 lets the PHY request periodic updates
// - divide ratio bits 7..0 reset 0x7B; high nibble ODT, low drive
// - reserved bits of the second register read as zero
module zqictl_regs (
   input  wire         clk,          // system clock, 50 MHz
   input  wire         resetn,       // async reset, active low
   input  wire         ce,           // clock enable, freezes all state
   input  wire [7:0]   regAddr,      // register byte address
   input  wire [31:0]  regWdata,     // register write data
   input  wire         regWrite,     // write strobe
   input  wire         regRead,      // read strobe
   output reg  [31:0]  regRdata,     // read data, cycle after strobe
   input  wire         dfiCtlUpdReq, // DFI update request level
   input  wire [3:0]   phyDriftReq,  // per-instance drift update wish
   output reg          dfiPhyUpdReq, // periodic update request to DFI
   input  wire [111:0] engineCodes,  // calibrated codes, 28 per instance
   input  wire [3:0]   engineDone,   // engine done per instance
   output wire [3:0]   calStart,     // start pulse per instance
   output wire [3:0]   calBypass,    // bypass to engine while running
   output wire [3:0]   padPowerDown, // power-down per instance
   output wire [111:0] padCodes,     // pad codes, 28 per instance
   output wire [15:0]  odtDivide,    // termination divide, 4 per inst
   output wire [15:0]  drvDivide     // drive divide, 4 per instance
);

   // ************************************************************
   // storage
   // ************************************************************
   reg  [31:0] ctlFirst_reg  [0:3];
   reg  [31:0] ctlSecond_reg [0:3];
   reg  [3:0]  done_reg;
   reg  [3:0]  done_next;
   reg  [3:0]  bypd_reg;
   reg  [3:0]  bypd_next;
   reg         trig_reg;
   reg         dfiPrev_reg;
   reg  [31:0] readMux;
   wire [3:0]  calBusy;
   wire [3:0]  calEnd;
   wire [3:0]  calBypassed;
   wire [3:0]  wDec;
   wire [3:0]  rDec;
   wire        swTrig;
   wire        statWrite;
   reg  [3:0]  puMask;
   integer     i;

   // {hit, second, instance}
   function [3:0] decodeCtl;
      input [7:0] a;
      begin
         decodeCtl = {(a < `ZQI_CTL_SPAN) && (a[1:0] == 2'b00),
                      a[2], a[4:3]};
      end
   endfunction

   assign wDec      = decodeCtl(regAddr);
   assign rDec      = decodeCtl(regAddr);
   assign swTrig    = regWrite && (regAddr == `ZQI_INIT_ADDR) &&
                      regWdata[`ZQI_TRIG_BIT];
   assign statWrite = regWrite && (regAddr == `ZQI_STAT_ADDR);

   // ************************************************************
   // control register writes
   // ************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < 4; i = i + 1) begin
            ctlFirst_reg[i]  <= `ZQI_FIRST_RST;
            ctlSecond_reg[i] <= `ZQI_SECOND_RST;
         end
      end else if (ce && regWrite && wDec[3]) begin
         if (wDec[2]) begin
            ctlSecond_reg[wDec[1:0]] <= regWdata & `ZQI_SECOND_MASK;
         end else begin
            ctlFirst_reg[wDec[1:0]] <= regWdata;
         end
      end
   end

   // ************************************************************
   // calibration trigger
   // ************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_reg    <= 1'b0;
         dfiPrev_reg <= 1'b0;
      end else if (ce) begin
         dfiPrev_reg <= dfiCtlUpdReq;
         trig_reg    <= swTrig || (dfiCtlUpdReq && !dfiPrev_reg);
      end
   end

   // ************************************************************
   // per-instance sequencers
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : inst
         zqictl_cal_unit u_cal (
            .clk           (clk),
            .resetn        (resetn),
            .ce            (ce),
            .calEnable     (ctlFirst_reg[g][`ZQI_EN_BIT]),
            .powerDown     (ctlFirst_reg[g][`ZQI_PD_BIT]),
            .bypass        (ctlFirst_reg[g][`ZQI_BYP_BIT]),
            .overrideEn    (ctlFirst_reg[g][`ZQI_OVR_BIT]),
            .overrideCodes (ctlFirst_reg[g][`ZQI_CODE_MSB:0]),
            .trigger       (trig_reg),
            .engineCodes   (engineCodes[g*28 +: 28]),
            .engineDone    (engineDone[g]),
            .calStart      (calStart[g]),
            .calBusy       (calBusy[g]),
            .calEnd        (calEnd[g]),
            .calBypassed   (calBypassed[g]),
            .padCodes      (padCodes[g*28 +: 28])
         );
         assign padPowerDown[g] = ctlFirst_reg[g][`ZQI_PD_BIT];
         assign calBypass[g]    = calBusy[g] &&
                                  ctlFirst_reg[g][`ZQI_BYP_BIT];
         assign odtDivide[g*4 +: 4] =
            ctlSecond_reg[g][`ZQI_ODT_MSB:`ZQI_ODT_LSB];
         assign drvDivide[g*4 +: 4] =
            ctlSecond_reg[g][`ZQI_DRV_MSB:0];
      end
   endgenerate

   // ************************************************************
   // status flags and periodic update request
   // ************************************************************
   always @* begin
      done_next = done_reg;
      bypd_next = bypd_reg;
      puMask    = 4'h0;
      if (ce && statWrite) begin
         done_next = done_next & ~regWdata[`ZQI_DONE_LSB +: 4];
         bypd_next = bypd_next & ~regWdata[`ZQI_BYPD_LSB +: 4];
      end
      done_next = done_next | calEnd;
      bypd_next = bypd_next | calBypassed;
      for (i = 0; i < 4; i = i + 1) begin
         puMask[i] = ctlSecond_reg[i][`ZQI_PU_BIT];
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_reg     <= 4'h0;
         bypd_reg     <= 4'h0;
         dfiPhyUpdReq <= 1'b0;
      end else if (ce) begin
         done_reg     <= done_next;
         bypd_reg     <= bypd_next;
         dfiPhyUpdReq <= |(phyDriftReq & puMask);
      end
   end

   // ************************************************************
   // read back
   // ************************************************************
   always @* begin
      readMux = 32'h0000_0000;
      if (rDec[3]) begin
         if (rDec[2]) begin
            readMux = ctlSecond_reg[rDec[1:0]] & `ZQI_SECOND_MASK;
         end else begin
            readMux = ctlFirst_reg[rDec[1:0]];
         end
      end else if (regAddr == `ZQI_STAT_ADDR) begin
         readMux[`ZQI_BUSY_LSB +: 4] = calBusy;
         readMux[`ZQI_DONE_LSB +: 4] = done_reg;
         readMux[`ZQI_BYPD_LSB +: 4] = bypd_reg;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regRdata <= 32'h0000_0000;
      end else if (ce) begin
         if (regRead) begin
            regRdata <= readMux;
         end else begin
            regRdata <= 32'h0000_0000;
         end
      end
   end

endmodule // zqictl_regs
`default_nettype wire

// ### tb/zqictl_chk.sv
// Purpose: port assertions for the impedance control bank
// Assumes: one clock, ce held high by the bench
// Notes:   bound to zqictl_regs from the bench top
`timescale 1ns/1ps
`default_nettype none
module zqictl_chk (
   input wire logic         clk,          // clock
   input wire logic         resetn,       // reset
   input wire logic [7:0]   regAddr,      // address
   input wire logic [31:0]  regWdata,     // write data
   input wire logic         regWrite,     // write strobe
   input wire logic         regRead,      // read strobe
   input wire logic [31:0]  regRdata,     // read data
   input wire logic         dfiCtlUpdReq, // dfi request
   input wire logic [3:0]   phyDriftReq,  // drift wish
   input wire logic         dfiPhyUpdReq, // periodic request
   input wire logic [3:0]   calStart,     // start pulses
   input wire logic [3:0]   calBypass,    // bypass
   input wire logic [3:0]   padPowerDown, // power-down
   input wire logic [111:0] padCodes,     // pad codes
   input wire logic [15:0]  odtDivide,    // odt divide
   input wire logic [15:0]  drvDivide     // drive divide
);
   // ****
   // trigger seen at the ports
   // ****
   logic dfiLast_reg;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) dfiLast_reg <= 1'b0;
      else dfiLast_reg <= dfiCtlUpdReq;
   wire trig = (dfiCtlUpdReq && !dfiLast_reg) ||
               (regWrite && regAddr == 8'h20 && regWdata[0]);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_read_idle: assert property (
      $past(!regRead || regAddr >= 8'h28) |-> regRdata == 32'h0000_0000)
      else $error("read data outside read slot");
   a_second_resv: assert property (
      $past(regRead && regAddr[2] && regAddr < 8'h20)
      |-> (regRdata & 32'hFFFE_FF00) == 32'h0000_0000)
      else $error("reserved bits not zero");
   a_pd_pin: assert property (
      regWrite && regAddr == 8'h00 |=> padPowerDown[0] == $past(regWdata[31]))
      else $error("power-down pin mismatch");
   a_div_pin: assert property (
      regWrite && regAddr == 8'h0C
      |=> {odtDivide[7:4], drvDivide[7:4]} == $past(regWdata[7:0]))
      else $error("divide pins mismatch");
   a_trig_start: assert property (
      |calStart |-> $past(trig, 2))
      else $error("start without trigger");
   a_start_pulse: assert property (calStart[0] |=> !calStart[0])
      else $error("start pulse too long");
   a_pd_blocks: assert property (
      padPowerDown[3] && $past(padPowerDown[3]) |-> !calStart[3])
      else $error("start while powered down");
   a_bypass_ends: assert property (calBypass[3] |=> !calBypass[3])
      else $error("bypass did not end run");
   a_ovr_codes: assert property (
      regWrite && regAddr == 8'h08 && regWdata[28]
      ##1 !(regWrite && regAddr == 8'h08)
      |=> padCodes[55:28] == $past(regWdata[27:0], 2))
      else $error("override codes not applied");
   a_drift_off: assert property (phyDriftReq == 4'h0 |=> !dfiPhyUpdReq)
      else $error("periodic request without wish");
endmodule // zqictl_chk
`default_nettype wire

// ### tb/zqictl_engine.sv
// Purpose: calibration engine model, one counter per instance
// Assumes: instance n answers 1 + 4n cycles after its start
// Notes:   codes are a fixed pattern per instance
`timescale 1ns/1ps
`default_nettype none
module zqictl_engine (
   input  wire logic         clk,         // clock
   input  wire logic         resetn,      // reset
   input  wire logic [3:0]   calStart,    // start pulses
   input  wire logic [3:0]   calBypass,   // bypass
   output logic      [3:0]   engineDone,  // done pulses
   output logic      [111:0] engineCodes  // codes
);
   // ****
   // run counters
   // ****
   logic [3:0] cnt_reg [4];
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) cnt_reg <= '{default: 4'h0};
      else
         for (int n = 0; n < 4; n++)
            if (calStart[n]) cnt_reg[n] <= 4'(1 + 4 * n);
            else if (calBypass[n]) cnt_reg[n] <= 4'h0;
            else if (cnt_reg[n] != 4'h0) cnt_reg[n] <= cnt_reg[n] - 4'h1;
   always_comb
      for (int n = 0; n < 4; n++) begin
         engineDone[n] = cnt_reg[n] == 4'h1;
         engineCodes[28*n +: 28] = 28'h123_4567 + 28'(n);
      end
endmodule // zqictl_engine
`default_nettype wire

// ### tb/testbench.sv
// Purpose: directed tests of the impedance control bank
// Assumes: ce tied high, engine model on the far side
// Notes:   map first 8n, second 8n+4, init 0x20, status 0x24
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic         clk, dfiPhyUpdReq;
   logic         resetn = 1'b0;
   logic         regWrite = 1'b0;
   logic         regRead = 1'b0;
   logic         dfiCtlUpdReq = 1'b0;
   logic [7:0]   regAddr = 8'h00;
   logic [31:0]  regWdata = 32'h0000_0000;
   logic [31:0]  regRdata;
   logic [3:0]   phyDriftReq = 4'h0;
   logic [3:0]   engineDone, calStart, calBypass, padPowerDown;
   logic [111:0] engineCodes, padCodes;
   logic [15:0]  odtDivide, drvDivide;
   logic [27:0]  ov;
   int           err_count = 0;
   int           total_checks = 0;
   zqictl_regs u_zqictl_regs (.clk, .resetn, .ce(1'b1), .regAddr, .regWdata,
      .regWrite, .regRead, .regRdata, .dfiCtlUpdReq, .phyDriftReq,
      .dfiPhyUpdReq, .engineCodes, .engineDone, .calStart, .calBypass,
      .padPowerDown, .padCodes, .odtDivide, .drvDivide);
   zqictl_engine u_zqictl_engine (.clk, .resetn, .calStart, .calBypass,
      .engineDone, .engineCodes);
   // ****
   // bus tasks and checks
   // ****
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(int a, logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= 8'(a);
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(int a, logic [31:0] e);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= 8'(a);
      @(posedge clk);
      regRead <= 1'b0;
      #1 check("read data", regRdata, e);
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wait_start(int n);
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         #1;
         if (calStart[n] === 1'b1) break;
      end
      if (i == 50) begin
         err_count++;
         print_verdict();
      end
   endtask
   initial begin
      tick(3);
      resetn <= 1'b1;
      for (int n = 0; n < 4; n++) begin
         rd(8 * n, 32'h4000_014A);
         rd(8 * n + 4, 32'h0000_007B);
         check("pad reset", padCodes[28*n +: 28], 28'h000_014A);
      end
      check("div reset", {odtDivide, drvDivide}, 32'h7777_BBBB);
      check("pd reset", padPowerDown, 4'h0);
      $display("reset test done");
      for (int n = 0; n < 4; n++) begin
         wr(8 * n + 4, 32'hFFFF_FF00 | 32'(17 * n));
         wr(8 * n, {4'h1, 7'h7F - 7'(n), 7'(n), 7'h55, 7'h2A});
      end
      tick(2);
      check("div", {odtDivide, drvDivide}, 32'h3210_3210);
      for (int n = 0; n < 4; n++) begin
         rd(8 * n + 4, 32'h0001_0000 | 32'(17 * n));
         ov = padCodes[28*n +: 28];
         check("pu odt", ov[27:21], 7'h7F - 7'(n));
         check("pd odt", ov[20:14], 7'(n));
         check("drive", ov[13:0], {7'h55, 7'h2A});
      end
      rd(8'h30, 32'h0000_0000);
      $display("register test done");
      wr(8'h00, 32'h4000_014A);
      wr(8'h08, 32'h4000_014A);
      wr(8'h10, 32'h0000_014A);
      wr(8'h18, 32'hC000_014A);
      wr(8'h20, 32'h0000_0001);
      wait_start(1);
      tick(8);
      for (int n = 0; n < 4; n++)
         check("codes", padCodes[28*n +: 28],
               n < 2 ? 28'h123_4567 + 28'(n) : 28'h000_014A);
      check("pd pins", padPowerDown, 4'h8);
      $display("calibration test done");
      wr(8'h18, 32'h4000_014A);
      dfiCtlUpdReq <= 1'b1;
      tick(1);
      wait_start(3);
      wr(8'h18, 32'h6000_014A);
      #1 check("bypass pins", calBypass, 4'h8);
      tick(16);
      check("bypassed code", padCodes[111:84], 28'h000_014A);
      rd(8'h24, 32'h0000_8B00);
      $display("dfi bypass test done");
      wr(8'h04, 32'h0000_007B);
      phyDriftReq <= 4'h1;
      tick(2);
      check("drift off", dfiPhyUpdReq, 1'b0);
      phyDriftReq <= 4'h2;
      tick(2);
      check("drift on", dfiPhyUpdReq, 1'b1);
      $display("periodic test done");
      print_verdict();
   end
endmodule // testbench
bind zqictl_regs zqictl_chk u_zqictl_chk (.clk, .resetn, .regAddr, .regWdata,
   .regWrite, .regRead, .regRdata, .dfiCtlUpdReq, .phyDriftReq, .dfiPhyUpdReq,
   .calStart, .calBypass, .padPowerDown, .padCodes, .odtDivide, .drvDivide);
`default_nettype wire
